// ===== src/miu_pkg.sv
// Purpose: Shared constants of the motion interrupt unit
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses of aligned words
package miu_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] MIU_OFS_X_ENABLE  = 8'h00;
   localparam logic [7:0] MIU_OFS_X_STATUS  = 8'h04;
   localparam logic [7:0] MIU_OFS_Y_ENABLE  = 8'h08;
   localparam logic [7:0] MIU_OFS_Y_STATUS  = 8'h0C;
   localparam logic [7:0] MIU_OFS_INTERP    = 8'h10;
   localparam logic [7:0] MIU_OFS_COMMAND   = 8'h14;
   localparam logic [7:0] MIU_OFS_MAIN_STAT = 8'h18;

   // ----------------------------------------------------------------
   // Axis enable and status fields
   // ----------------------------------------------------------------
   localparam int         MIU_AXIS_EVENTS   = 7;
   localparam int         MIU_EN_LSB        = 9;
   localparam int         MIU_ST_LSB        = 1;
   localparam int         MIU_EV_GE_LO      = 0;
   localparam int         MIU_EV_LT_LO      = 1;
   localparam int         MIU_EV_LT_HI      = 2;
   localparam int         MIU_EV_GE_HI      = 3;
   localparam int         MIU_EV_DEC_ENTRY  = 4;
   localparam int         MIU_EV_CONST_ENTRY = 5;
   localparam int         MIU_EV_DRIVE_DONE = 6;
   localparam logic [15:0] MIU_ENABLE_RST   = 16'h0000;

   // ----------------------------------------------------------------
   // Interpolation mode and main status fields
   // ----------------------------------------------------------------
   localparam int         MIU_CI_EN_BIT     = 14;
   localparam int         MIU_BP_EN_BIT     = 15;
   localparam logic [15:0] MIU_INTERP_RST   = 16'h0000;
   localparam int         MIU_MS_IDRV_BIT   = 8;
   localparam int         MIU_MS_NEXT_BIT   = 9;
   localparam int         MIU_MS_BPS_LSB    = 13;
   localparam int         MIU_MS_IRQ_BIT    = 15;
   localparam logic [1:0] MIU_SC_FROM       = 2'h2;
   localparam logic [1:0] MIU_SC_TO         = 2'h1;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] MIU_CMD_IRQ_CLEAR = 8'h3D;
   localparam logic [7:0] MIU_CMD_INTP_LO   = 8'h30;
   localparam logic [7:0] MIU_CMD_INTP_HI   = 8'h37;
   localparam logic [7:0] MIU_CMD_BP_PUSH   = 8'h38;

endpackage

// ===== src/miu_axis_if.sv
// Purpose: Enable and status link between top and one axis
// Assumes: Single clock domain
// Notes:   Clear is a one-cycle pulse from the register slave
`timescale 1ns/1ps
interface miu_axis_if;
   logic [6:0] enable;
   logic [6:0] status;
   logic       clear;

   modport core (output enable, output clear, input status);
   modport axis (input enable, input clear, output status);
endinterface

// ===== src/miu_axis_events.sv
// Purpose: Event detect and status latch for one axis
// Assumes: Position and compare values synchronous to mclk
// Notes:   Compare events fire on the cycle a condition turns true
`timescale 1ns/1ps
module miu_axis_events
   import miu_pkg::*;
#(
   parameter int POS_W = 32
)(
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   // Position and compare values
   input  wire logic signed [POS_W-1:0] position,
   input  wire logic signed [POS_W-1:0] compare_lo,
   input  wire logic signed [POS_W-1:0] compare_hi,
   // Drive profile pulses
   input  wire logic                    decel_entry,
   input  wire logic                    const_speed_entry,
   input  wire logic                    drive_done,
   // Link to the register slave
   miu_axis_if.axis                     link
);

   logic [3:0] cond_now;
   logic [3:0] cond_r;
   logic [6:0] event_now;
   logic [6:0] status_r;

   // ----------------------------------------------------------------
   // Compare conditions and edge detect
   // ----------------------------------------------------------------
   always_comb begin
      cond_now[MIU_EV_GE_LO] = (position >= compare_lo);
      cond_now[MIU_EV_LT_LO] = (position <  compare_lo);
      cond_now[MIU_EV_LT_HI] = (position <  compare_hi);
      cond_now[MIU_EV_GE_HI] = (position >= compare_hi);
   end

   // Previous condition, so a steady state raises no repeated event
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cond_r <= 4'h0;
      end else begin
         cond_r <= cond_now;
      end
   end

   always_comb begin
      event_now[3:0]              = cond_now & ~cond_r;
      event_now[MIU_EV_DEC_ENTRY]   = decel_entry;
      event_now[MIU_EV_CONST_ENTRY] = const_speed_entry;
      event_now[MIU_EV_DRIVE_DONE]  = drive_done;
   end

   // ----------------------------------------------------------------
   // Status latch
   // ----------------------------------------------------------------
   // A new event in the clearing cycle survives the read clear
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         status_r <= 7'h00;
      end else begin
         status_r <= (link.clear ? 7'h00 : status_r)
                   | (event_now & link.enable);
      end
   end

   assign link.status = status_r;

endmodule

// ===== src/miu_top.sv
// Purpose: Interrupt unit of a two-axis pulse motion controller
// Assumes: Wishbone classic slave on mclk; axis core inputs synchronous
// Notes:   Interrupt pin is open drain, driven low only while pending
`timescale 1ns/1ps

module miu_top
   import miu_pkg::*;
#(
   parameter int POS_W = 32
)(
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   // Wishbone classic slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // X axis core
   input  wire logic signed [POS_W-1:0] x_position,
   input  wire logic signed [POS_W-1:0] x_compare_lo,
   input  wire logic signed [POS_W-1:0] x_compare_hi,
   input  wire logic                    x_decel_entry,
   input  wire logic                    x_const_speed_entry,
   input  wire logic                    x_drive_done,
   // Y axis core
   input  wire logic signed [POS_W-1:0] y_position,
   input  wire logic signed [POS_W-1:0] y_compare_lo,
   input  wire logic signed [POS_W-1:0] y_compare_hi,
   input  wire logic                    y_decel_entry,
   input  wire logic                    y_const_speed_entry,
   input  wire logic                    y_drive_done,
   // Interpolation core
   input  wire logic                    interp_active,
   input  wire logic                    next_segment_ready,
   input  wire logic [1:0]              stack_counter,
   input  wire logic [1:0]              bitpat_stack_state,
   // Command strobe to the rest of the device
   output logic      [7:0]              cmd_code,
   output logic                         cmd_stb,
   // Open-drain interrupt pin
   output logic                         host_irq_line_n_o,
   output logic                         host_irq_line_n_oe
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MIU_SEL_NONE,
      MIU_SEL_X_EN,
      MIU_SEL_X_ST,
      MIU_SEL_Y_EN,
      MIU_SEL_Y_ST,
      MIU_SEL_INTERP,
      MIU_SEL_CMD,
      MIU_SEL_MAIN
   } miu_sel_t;

   miu_axis_if x_link ();
   miu_axis_if y_link ();

   miu_sel_t    sel_now;
   logic        req_now;
   logic        wr_now;
   logic        rd_now;
   logic [15:0] wr_half;
   logic [15:0] x_enable_r;
   logic [15:0] y_enable_r;
   logic [15:0] interp_mode_r;
   logic        x_clear_now;
   logic        y_clear_now;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [7:0]  cmd_code_r;
   logic        cmd_stb_r;
   logic        cmd_intp_now;
   logic        cmd_bp_now;
   logic        cmd_clr_now;
   logic        next_ready_r;
   logic [1:0]  stack_r;
   logic        interp_active_r;
   logic        interp_end_now;
   logic        ci_set_now;
   logic        bp_set_now;
   logic        ci_pend_r;
   logic        bp_pend_r;
   logic        axis_pend_now;
   logic        irq_oe_r;

   // ----------------------------------------------------------------
   // Axis event blocks
   // ----------------------------------------------------------------
   miu_axis_events #(
      .POS_W             (POS_W)
   ) u_x_axis (
      .mclk              (mclk),
      .nrst              (nrst),
      .position          (x_position),
      .compare_lo        (x_compare_lo),
      .compare_hi        (x_compare_hi),
      .decel_entry       (x_decel_entry),
      .const_speed_entry (x_const_speed_entry),
      .drive_done        (x_drive_done),
      .link              (x_link.axis)
   );

   miu_axis_events #(
      .POS_W             (POS_W)
   ) u_y_axis (
      .mclk              (mclk),
      .nrst              (nrst),
      .position          (y_position),
      .compare_lo        (y_compare_lo),
      .compare_hi        (y_compare_hi),
      .decel_entry       (y_decel_entry),
      .const_speed_entry (y_const_speed_entry),
      .drive_done        (y_drive_done),
      .link              (y_link.axis)
   );

   // Enable fields sit in the upper byte of each axis enable word
   assign x_link.enable = x_enable_r[MIU_EN_LSB +: MIU_AXIS_EVENTS];
   assign y_link.enable = y_enable_r[MIU_EN_LSB +: MIU_AXIS_EVENTS];
   assign x_link.clear  = x_clear_now;
   assign y_link.clear  = y_clear_now;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Request is taken only in the cycle before ack rises
   assign req_now = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_now  = req_now & wb_we_i;
   assign rd_now  = req_now & ~wb_we_i;

   always_comb begin
      case (wb_adr_i)
         MIU_OFS_X_ENABLE:  sel_now = MIU_SEL_X_EN;
         MIU_OFS_X_STATUS:  sel_now = MIU_SEL_X_ST;
         MIU_OFS_Y_ENABLE:  sel_now = MIU_SEL_Y_EN;
         MIU_OFS_Y_STATUS:  sel_now = MIU_SEL_Y_ST;
         MIU_OFS_INTERP:    sel_now = MIU_SEL_INTERP;
         MIU_OFS_COMMAND:   sel_now = MIU_SEL_CMD;
         MIU_OFS_MAIN_STAT: sel_now = MIU_SEL_MAIN;
         default:           sel_now = MIU_SEL_NONE;
      endcase
   end

   // Byte lanes above bit 15 address nothing and are dropped
   always_comb begin
      wr_half[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0]  : 8'h00;
      wr_half[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;
   end

   // ----------------------------------------------------------------
   // Acknowledge
   // ----------------------------------------------------------------
   // One wait state; ack drops the cycle after it is given
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req_now;
      end
   end

   // ----------------------------------------------------------------
   // Enable registers
   // ----------------------------------------------------------------
   // Per-lane update keeps the other byte of a half-word write intact
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         x_enable_r    <= MIU_ENABLE_RST;
         y_enable_r    <= MIU_ENABLE_RST;
         interp_mode_r <= MIU_INTERP_RST;
      end else if (wr_now) begin
         if (sel_now == MIU_SEL_X_EN) begin
            if (wb_sel_i[0]) x_enable_r[7:0]  <= wr_half[7:0];
            if (wb_sel_i[1]) x_enable_r[15:8] <= wr_half[15:8];
         end
         if (sel_now == MIU_SEL_Y_EN) begin
            if (wb_sel_i[0]) y_enable_r[7:0]  <= wr_half[7:0];
            if (wb_sel_i[1]) y_enable_r[15:8] <= wr_half[15:8];
         end
         if (sel_now == MIU_SEL_INTERP) begin
            if (wb_sel_i[0]) interp_mode_r[7:0]  <= wr_half[7:0];
            if (wb_sel_i[1]) interp_mode_r[15:8] <= wr_half[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read-clear of axis status
   // ----------------------------------------------------------------
   // Clear lands on the edge that takes the read snapshot, so an
   // event latched one edge earlier cannot be wiped unread
   assign x_clear_now = rd_now & (sel_now == MIU_SEL_X_ST);
   assign y_clear_now = rd_now & (sel_now == MIU_SEL_Y_ST);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Enable and command words are write-only and read as zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (sel_now)
         MIU_SEL_X_ST: begin
            rdata_nxt[MIU_ST_LSB +: MIU_AXIS_EVENTS] = x_link.status;
         end
         MIU_SEL_Y_ST: begin
            rdata_nxt[MIU_ST_LSB +: MIU_AXIS_EVENTS] = y_link.status;
         end
         MIU_SEL_INTERP: begin
            rdata_nxt[15:0] = interp_mode_r;
         end
         MIU_SEL_MAIN: begin
            rdata_nxt[MIU_MS_IDRV_BIT]      = interp_active;
            rdata_nxt[MIU_MS_NEXT_BIT]      = next_segment_ready;
            rdata_nxt[MIU_MS_BPS_LSB +: 2]  = bitpat_stack_state;
            rdata_nxt[MIU_MS_IRQ_BIT]       = irq_oe_r;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_now) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Command register
   // ----------------------------------------------------------------
   // Only the low byte carries a command; other lanes are ignored
   always_comb begin
      cmd_clr_now  = 1'b0;
      cmd_intp_now = 1'b0;
      cmd_bp_now   = 1'b0;
      if (wr_now && sel_now == MIU_SEL_CMD && wb_sel_i[0]) begin
         cmd_clr_now  = (wb_dat_i[7:0] == MIU_CMD_IRQ_CLEAR);
         cmd_intp_now = (wb_dat_i[7:0] >= MIU_CMD_INTP_LO) && (wb_dat_i[7:0] <= MIU_CMD_INTP_HI);
         cmd_bp_now   = (wb_dat_i[7:0] == MIU_CMD_BP_PUSH);
      end
   end

   // Command code is passed on so the motion core can act on it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmd_code_r <= 8'h00;
         cmd_stb_r  <= 1'b0;
      end else begin
         cmd_stb_r <= wr_now & (sel_now == MIU_SEL_CMD) & wb_sel_i[0];
         if (wr_now && sel_now == MIU_SEL_CMD && wb_sel_i[0]) begin
            cmd_code_r <= wb_dat_i[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interpolation event detect
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         next_ready_r    <= 1'b0;
         stack_r         <= 2'h0;
         interp_active_r <= 1'b0;
      end else begin
         next_ready_r    <= next_segment_ready;
         stack_r         <= stack_counter;
         interp_active_r <= interp_active;
      end
   end

   // Edge on next-ready, so a held level does not re-arm after clear
   assign ci_set_now     = interp_mode_r[MIU_CI_EN_BIT] & interp_active
                         & next_segment_ready & ~next_ready_r;
   assign bp_set_now     = interp_mode_r[MIU_BP_EN_BIT] & interp_active
                         & (stack_r == MIU_SC_FROM)
                         & (stack_counter == MIU_SC_TO);
   assign interp_end_now = interp_active_r & ~interp_active;

   // ----------------------------------------------------------------
   // Interpolation pending flags
   // ----------------------------------------------------------------
   // Set beats every clear source in the same cycle
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ci_pend_r <= 1'b0;
      end else if (ci_set_now) begin
         ci_pend_r <= 1'b1;
      end else if (cmd_intp_now || cmd_clr_now || interp_end_now) begin
         ci_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bp_pend_r <= 1'b0;
      end else if (bp_set_now) begin
         bp_pend_r <= 1'b1;
      end else if (cmd_bp_now || cmd_clr_now || interp_end_now) begin
         bp_pend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt line
   // ----------------------------------------------------------------
   // Status gated again by enable, so masking later also releases
   assign axis_pend_now = |(x_link.status & x_link.enable)
                        | |(y_link.status & y_link.enable);

   // Registered combine costs one cycle of latency on the pin
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         irq_oe_r <= 1'b0;
      end else begin
         irq_oe_r <= axis_pend_now
                   | (ci_pend_r & interp_mode_r[MIU_CI_EN_BIT])
                   | (bp_pend_r & interp_mode_r[MIU_BP_EN_BIT]);
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_ack_o           = ack_r;
   assign wb_dat_o           = rdata_r;
   assign cmd_code           = cmd_code_r;
   assign cmd_stb            = cmd_stb_r;
   assign host_irq_line_n_o  = 1'b0;      // Open drain: only ever pulls low
   assign host_irq_line_n_oe = irq_oe_r;

endmodule

// ===== tb/miu_chk.sv
// Purpose: Port-level assertions of the motion interrupt unit
// Assumes: Bound to miu_top, one clock domain
// Notes:   Enables are mirrored from bus writes seen at the ports
`timescale 1ns/1ps
module miu_chk
   import miu_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // Register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Sources and pin
   input wire logic        x_drive_done,
   input wire logic        interp_active,
   input wire logic        host_irq_line_n_o,
   input wire logic        host_irq_line_n_oe
);
   logic [6:0] x_en_r;
   logic [6:0] y_en_r;
   logic [1:0] im_r;
   logic       take;
   logic       axis_off;
   logic       none_en;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Write taken at this edge, upper lane only
   assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1];
   assign axis_off = (x_en_r | y_en_r) == 7'h00;
   assign none_en = axis_off && im_r == 2'h0;
   // Mirror of the enables; lands on the edge the write is taken
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         x_en_r <= 7'h00;
         y_en_r <= 7'h00;
         im_r <= 2'h0;
      end else if (take) begin
         if (wb_adr_i == MIU_OFS_X_ENABLE) x_en_r <= wb_dat_i[15:9];
         if (wb_adr_i == MIU_OFS_Y_ENABLE) y_en_r <= wb_dat_i[15:9];
         if (wb_adr_i == MIU_OFS_INTERP) im_r <= wb_dat_i[15:14];
      end
   end
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered after one cycle");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data seen without ack");
   reset_quiet_a: assert property ($rose(nrst) |-> !host_irq_line_n_oe)
      else $error("pin driven right after reset");
   pull_low_a: assert property (host_irq_line_n_oe |-> !host_irq_line_n_o)
      else $error("pin driven high");
   done_irq_a: assert property (x_drive_done && x_en_r[6] |-> ##[1:3] host_irq_line_n_oe)
      else $error("enabled drive end did not pull the pin");
   masked_a: assert property (none_en && $past(none_en) |-> !host_irq_line_n_oe)
      else $error("pin driven with every source masked");
   interp_end_a: assert property ($fell(interp_active) && axis_off |-> ##[1:3] !host_irq_line_n_oe)
      else $error("pin not released at interpolation end");
endmodule

// ===== tb/miu_host.sv
// Purpose: Host processor model: bus master and pulled-up pin
// Assumes: Wishbone classic, one request at a time
// Notes:   A released pin reads high through the pull-up
`timescale 1ns/1ps
module miu_host (
   // Clock
   input wire logic   mclk,
   // Bus to the device
   output logic       wb_cyc_i,
   output logic       wb_stb_i,
   output logic       wb_we_i,
   output logic [7:0] wb_adr_i,
   output logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_i,
   input wire logic   wb_ack_o,
   // Interrupt pin
   input wire logic   host_irq_line_n_o,
   input wire logic   host_irq_line_n_oe,
   output logic       irq_n
);
   // Pull-up wins whenever the device lets go
   assign irq_n = host_irq_line_n_oe ? host_irq_line_n_o : 1'b1;
   assign wb_stb_i = wb_cyc_i;
   assign wb_sel_i = 4'h3;
   // Idle bus at time zero
   initial begin
      wb_cyc_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
   end
   // Hold the request until ack is sampled, then idle one cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0, d};
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      @(posedge mclk);
   endtask
endmodule

// ===== tb/miu_top_tb.sv
// Purpose: Self-checking bench of the motion interrupt unit
// Assumes: Host model drives the bus, bench drives the cores
// Notes:   Read answers are checked against a queue of notes
`timescale 1ns/1ps
module miu_top_tb;
   import miu_pkg::*;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   wire logic wb_cyc_i, wb_stb_i, wb_we_i, irq_n;
   wire logic [7:0] wb_adr_i;
   wire logic [3:0] wb_sel_i;
   wire logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, cmd_stb, host_irq_line_n_o, host_irq_line_n_oe;
   logic [7:0] cmd_code;
   logic signed [31:0] x_position, x_compare_lo, x_compare_hi, r;
   logic signed [31:0] y_position, y_compare_lo, y_compare_hi;
   wire logic x_decel_entry, x_const_speed_entry, x_drive_done;
   wire logic y_decel_entry, y_const_speed_entry, y_drive_done;
   logic [5:0] pls = 6'h00;
   logic interp_active = 1'b0;
   logic next_segment_ready = 1'b0;
   logic [1:0] stack_counter = 2'h0;
   logic [1:0] bitpat_stack_state;
   logic [31:0] seed = 32'h8D066849;
   logic [31:0] expq[$];
   logic signed [31:0] pv[3];
   logic [15:0] ev[3] = '{16'h0002, 16'h0010, 16'h000C};
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   assign {y_drive_done, y_const_speed_entry, y_decel_entry} = pls[5:3];
   assign {x_drive_done, x_const_speed_entry, x_decel_entry} = pls[2:0];
   miu_top dut (.*);
   miu_host h (.*);
   // 100 MHz clock
   always #5 mclk = ~mclk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      h.xfer(1'b1, a, d);
   endtask
   // Note first, so the monitor finds it when the answer comes
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      expq.push_back({16'h0, e});
      h.xfer(1'b0, a, 16'h0);
   endtask
   // Let the latch and the registered pin settle before looking
   task automatic pin(input logic e);
      repeat (3) @(posedge mclk);
      chk({31'h0, irq_n}, {31'h0, e});
   endtask
   task automatic pulse(input int k);
      @(posedge mclk);
      pls[k] <= 1'b1;
      @(posedge mclk);
      pls <= 6'h00;
      repeat (3) @(posedge mclk);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Compare each read answer with the oldest note
   always @(posedge mclk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (expq.size() == 0) begin
            n_fail++;
            $display("Error at %0t: seen %h expected no read", $time, wb_dat_o);
         end else begin
            chk(wb_dat_o, expq.pop_front());
         end
      end
      // Command strobe stands beside the ack of a command write
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b1 && wb_adr_i == MIU_OFS_COMMAND)
         chk({31'h0, cmd_stb}, 32'h1);
   end
   // Cut a hang short
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 5000) begin
         n_fail++;
         close_out();
      end
   end
   // Main sequence; random compare values keep counters off zero
   initial begin
      r = (xs() & 32'h0000FFFF) + 32'h100;
      pv = '{r, r + 100, r - 10};
      {x_compare_lo, x_compare_hi, x_position} <= {r, r + 32'sd100, r - 32'sd10};
      {y_compare_lo, y_compare_hi, y_position} <= {xs(), xs(), xs()};
      bitpat_stack_state <= 2'(xs());
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      rd(MIU_OFS_X_STATUS, 16'h0000);
      rd(MIU_OFS_MAIN_STAT, {1'b0, bitpat_stack_state, 13'h0});
      rd(MIU_OFS_INTERP, 16'h0000);
      rd(8'h1C, 16'h0000);
      pulse(5);
      rd(MIU_OFS_Y_STATUS, 16'h0000);
      pin(1'b1);
      wr(MIU_OFS_X_ENABLE, 16'hFE00);
      rd(MIU_OFS_X_ENABLE, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         x_position <= pv[i];
         repeat (3) @(posedge mclk);
         rd(MIU_OFS_X_STATUS, ev[i]);
      end
      pulse(0);
      pulse(1);
      pulse(2);
      pin(1'b0);
      rd(MIU_OFS_X_STATUS, 16'h00E0);
      pin(1'b1);
      wr(MIU_OFS_Y_ENABLE, 16'h8000);
      pulse(3);
      pulse(5);
      rd(MIU_OFS_Y_STATUS, 16'h0080);
      wr(MIU_OFS_INTERP, 16'hC000);
      rd(MIU_OFS_INTERP, 16'hC000);
      interp_active <= 1'b1;
      stack_counter <= 2'h2;
      @(posedge mclk);
      next_segment_ready <= 1'b1;
      pin(1'b0);
      rd(MIU_OFS_MAIN_STAT, {1'b1, bitpat_stack_state, 4'h1, 1'b1, 8'h00});
      next_segment_ready <= 1'b0;
      wr(MIU_OFS_COMMAND, 16'h0030);
      pin(1'b1);
      stack_counter <= 2'h1;
      pin(1'b0);
      wr(MIU_OFS_COMMAND, {8'h00, MIU_CMD_BP_PUSH});
      pin(1'b1);
      stack_counter <= 2'h2;
      pulse(2);
      next_segment_ready <= 1'b1;
      wr(MIU_OFS_COMMAND, {8'h00, MIU_CMD_IRQ_CLEAR});
      chk({24'h0, cmd_code}, {24'h0, MIU_CMD_IRQ_CLEAR});
      pin(1'b0);
      rd(MIU_OFS_X_STATUS, 16'h0080);
      pin(1'b1);
      next_segment_ready <= 1'b0;
      wr(MIU_OFS_X_ENABLE, 16'h0000);
      wr(MIU_OFS_Y_ENABLE, 16'h0000);
      next_segment_ready <= 1'b1;
      pin(1'b0);
      interp_active <= 1'b0;
      pin(1'b1);
      close_out();
   end
endmodule
bind miu_top miu_chk u_chk (.*);
